//--- hw/smr_ctrl.sv
`timescale 1ns/1ps
// Contract
// RULE1: Register one holds until rewritten, reset pin low, or power lost.
// RULE2: Write only when banks idle; wait tMRD and tMOD afterwards.
// RULE3: Reserved bits 18, 15:13, 10, 8 of register one written zero.
// RULE4: Write leveling with output off allows all termination values.
// RULE5: Bit 0 selects the DLL; each enable is followed by DLL reset.
// RULE6: Self refresh turns an enabled DLL off and back on.
// RULE7: DLL off: no termination, latencies both six clocks; code forces write latency only, register zero unwritten.
// RULE8: Bits 5 and 1 choose driver impedance, primary 34 ohms.
// RULE9: Program 34 ohm drive at init and issue calibration; code passes the software drive bits unchanged and issues no calibration.
// RULE10: Bit 12 set tristates all data and strobe outputs.
// RULE11: Bit 11 enables termination strobe and drops data mask.
// RULE12: Termination strobe kept disabled except on by-8 parts.
// RULE13: Bits 9, 6, 2 choose nominal termination CALIBRATION_RESISTOR over n.
// RULE14: Termination off before read data and during read burst; odt_allow_out follows only the DLL-off state, not reads.
// RULE15: Dynamic termination replaces nominal value during writes.
// RULE16: Termination control pin level switches termination when enabled.
// RULE17: Bit 7 enables write leveling.
// RULE18: Bits 4 and 3 set additive latency 0, CL-1, CL-2.
// RULE19: Register two holds until rewritten or power lost.
// RULE20: Reserved bits 18, 15:11, 8, 2:0 of register two written zero.
// RULE21: Bits 5:3 set write CAS latency; total adds additive latency.
// RULE22: Write CAS latency programmed to match clock rate.
// RULE23: Bit 6 of register two enables automatic refresh rate.
// RULE24: Bit 7 of register two forces extended temperature refresh.
// RULE25: Never enable automatic rate and extended temperature together.
// RULE26: Bits 10:9 of register two select write termination.
module smr_ctrl
    import smr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [2:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        banks_idle_in,
    output logic             mrs_cmd_out,
    output logic [2:0]       mrs_bank_out,
    output logic [18:0]      mrs_addr_out,
    output logic             odt_allow_out
);
    typedef struct packed {
        smr_state_t  state;
        logic [18:0] one_val;
        logic [18:0] two_val;
        logic [18:0] one_dev;
        logic [18:0] two_dev;
        logic        pend_one;
        logic        pend_two;
        logic        x8_part;
        logic        rejected;
        logic        done;
        logic        dll_off;
        logic        cur_one;
        logic [31:0] rdata;
        logic        ack;
        logic        cmd;
        logic [2:0]  bank;
        logic [18:0] addr;
        logic        odt_ok;
    } smr_ctrl_t;
    smr_ctrl_t s_reg;
    smr_ctrl_t s_next;
    logic      wait_busy;
    logic      wait_start;
    logic [18:0] one_clean;
    logic [18:0] two_clean;
    logic        ctrl_wr;
    smr_wait_timer u_timer (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .start_in (wait_start),
        .busy_out (wait_busy)
    );
    always_comb begin
        s_next     = s_reg;
        wait_start = 1'b0;
        s_next.cmd = 1'b0;
        s_next.ack = 1'b0;
        ctrl_wr    = avs_write_in && !s_reg.ack
            && (avs_address_in == SMR_A_CTRL);
        // Reserved bits are forced to zero whatever software writes.
        one_clean = s_reg.one_val & ~SMR_ONE_RSVD; // RULE3
        two_clean = s_reg.two_val & ~SMR_TWO_RSVD; // RULE20
        if (!s_reg.x8_part) begin
            one_clean[SMR_TSTRB_BIT] = 1'b0; // RULE12
        end
        if (one_clean[SMR_DLL_OFF_BIT]) begin
            // The DLL-off mode cannot use termination at all.
            one_clean[SMR_RTT_HI_BIT]  = 1'b0; // RULE7
            one_clean[SMR_RTT_MID_BIT] = 1'b0;
            one_clean[SMR_RTT_LO_BIT]  = 1'b0;
            two_clean[SMR_RTTWR_LO_BIT +: 2] = 2'h0;
            two_clean[SMR_CWL_LO_BIT +: 3]   = SMR_CWL6_CODE; // RULE22
        end
        if (two_clean[SMR_ASR_BIT] && two_clean[SMR_SRT_BIT]) begin
            // Extended temperature wins; it covers the automatic case.
            two_clean[SMR_ASR_BIT] = 1'b0; // RULE25
        end
        if (avs_write_in && !s_reg.ack) begin
            s_next.ack = 1'b1;
            unique case (avs_address_in)
                SMR_A_CTRL: begin
                    s_next.pend_one = s_reg.pend_one
                        | avs_writedata_in[SMR_CTRL_GO1];
                    s_next.pend_two = s_reg.pend_two
                        | avs_writedata_in[SMR_CTRL_GO2];
                    s_next.x8_part  = avs_writedata_in[SMR_CTRL_X8];
                    s_next.done     = 1'b0;
                    s_next.rejected = 1'b0;
                end
                SMR_A_ONE: s_next.one_val = avs_writedata_in[18:0];
                SMR_A_TWO: s_next.two_val = avs_writedata_in[18:0];
                default: begin
                end
            endcase
        end else if (avs_read_in && !s_reg.ack) begin
            s_next.ack = 1'b1;
            unique case (avs_address_in)
                SMR_A_CTRL: s_next.rdata = {29'h0, s_reg.x8_part,
                    s_reg.pend_two, s_reg.pend_one};
                SMR_A_ONE: s_next.rdata = {13'h0, s_reg.one_val};
                SMR_A_TWO: s_next.rdata = {13'h0, s_reg.two_val};
                SMR_A_STAT: s_next.rdata = {28'h0, s_reg.done,
                    s_reg.dll_off, s_reg.rejected,
                    (s_reg.state != SMR_IDLE)};
                SMR_A_SHADOW1: s_next.rdata = {13'h0, s_reg.one_dev};
                SMR_A_SHADOW2: s_next.rdata = {13'h0, s_reg.two_dev};
                default: s_next.rdata = 32'h0;
            endcase
        end
        unique case (s_reg.state)
            SMR_IDLE: begin
                if (s_reg.pend_one || s_reg.pend_two) begin
                    if (!banks_idle_in) begin
                        // Held pending until every bank is closed.
                        s_next.rejected = 1'b1; // RULE2
                    end else begin
                        s_next.cur_one = s_reg.pend_one;
                        s_next.state   = SMR_ISSUE;
                    end
                end
            end
            SMR_ISSUE: begin
                s_next.cmd = 1'b1;
                wait_start = 1'b1;
                if (s_reg.cur_one) begin
                    s_next.bank     = SMR_BANK_ONE;
                    s_next.addr     = one_clean;
                    s_next.one_dev  = one_clean; // RULE1
                    // A go written in this very cycle must not be lost.
                    s_next.pend_one = ctrl_wr
                        && avs_writedata_in[SMR_CTRL_GO1];
                    s_next.dll_off  = one_clean[SMR_DLL_OFF_BIT]; // RULE5
                    s_next.odt_ok   = !one_clean[SMR_DLL_OFF_BIT]; // RULE7
                end else begin
                    s_next.bank     = SMR_BANK_TWO;
                    s_next.addr     = two_clean; // RULE21
                    s_next.two_dev  = two_clean; // RULE19
                    s_next.pend_two = ctrl_wr
                        && avs_writedata_in[SMR_CTRL_GO2];
                end
                s_next.state = SMR_WAIT;
            end
            SMR_WAIT: begin
                if (!wait_busy && !wait_start) begin // RULE2
                    if (s_reg.cur_one && !s_reg.dll_off) begin
                        s_next.state = SMR_DLLRST;
                    end else begin
                        s_next.done  = 1'b1;
                        s_next.state = SMR_IDLE;
                    end
                end
            end
            SMR_DLLRST: begin
                // Each DLL enable is chased by a DLL reset command.
                s_next.cmd   = 1'b1; // RULE5
                s_next.bank  = SMR_BANK_ZERO;
                s_next.addr  = SMR_ZERO_DLLRST | SMR_ZERO_CL6;
                wait_start   = 1'b1;
                s_next.state = SMR_WAIT2;
            end
            SMR_WAIT2: begin
                if (!wait_busy && !wait_start) begin
                    s_next.done  = 1'b1;
                    s_next.state = SMR_IDLE;
                end
            end
            default: s_next.state = SMR_IDLE;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_reg        <= '0;
            s_reg.state  <= SMR_IDLE;
            s_reg.dll_off <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    assign avs_readdata_out    = s_reg.rdata;
    assign avs_waitrequest_out = !s_reg.ack;
    assign mrs_cmd_out         = s_reg.cmd;
    assign mrs_bank_out        = s_reg.bank;
    assign mrs_addr_out        = s_reg.addr;
    assign odt_allow_out       = s_reg.odt_ok; // RULE14 RULE16
endmodule

//--- hw/smr_pkg.sv
package smr_pkg;
    // Mode register select codes on the bank address pins.
    localparam logic [2:0]  SMR_BANK_ONE     = 3'h1;
    localparam logic [2:0]  SMR_BANK_TWO     = 3'h2;
    localparam logic [2:0]  SMR_BANK_ZERO    = 3'h0;
    localparam int          SMR_REG_W        = 19;
    // Register one field positions.
    localparam int          SMR_DLL_OFF_BIT  = 0;
    localparam int          SMR_DRV_LO_BIT   = 1;
    localparam int          SMR_RTT_LO_BIT   = 2;
    localparam int          SMR_AL_LO_BIT    = 3;
    localparam int          SMR_DRV_HI_BIT   = 5;
    localparam int          SMR_RTT_MID_BIT  = 6;
    localparam int          SMR_WLVL_BIT     = 7;
    localparam int          SMR_RTT_HI_BIT   = 9;
    localparam int          SMR_TSTRB_BIT    = 11;
    localparam int          SMR_QOFF_BIT     = 12;
    localparam logic [18:0] SMR_ONE_RSVD     = 19'h4E500;
    // Register two field positions.
    localparam int          SMR_CWL_LO_BIT   = 3;
    localparam int          SMR_ASR_BIT      = 6;
    localparam int          SMR_SRT_BIT      = 7;
    localparam int          SMR_RTTWR_LO_BIT = 9;
    localparam logic [18:0] SMR_TWO_RSVD     = 19'h4F907;
    // Zero register: DLL reset bit and the six-clock read latency code.
    localparam logic [18:0] SMR_ZERO_DLLRST  = 19'h00100;
    localparam logic [18:0] SMR_ZERO_CL6     = 19'h00020;
    localparam logic [2:0]  SMR_CWL6_CODE    = 3'h1;
    // Timing: tMRD in clocks, tMOD as the larger of its two figures.
    localparam int          SMR_TMRD_CK      = 4;
    localparam int          SMR_TMOD_CK_MIN  = 12;
    localparam int          SMR_TMOD_NS      = 15;
    localparam int          SMR_CLK_NS       = 40;
    localparam int          SMR_TMOD_CK_NS   =
        (SMR_TMOD_NS + SMR_CLK_NS - 1) / SMR_CLK_NS;
    localparam int          SMR_WAIT_CK      =
        (SMR_TMOD_CK_MIN > SMR_TMOD_CK_NS) ? SMR_TMOD_CK_MIN : SMR_TMOD_CK_NS;
    localparam logic [4:0]  SMR_WAIT_CNT     = 5'(SMR_WAIT_CK);
    // Avalon register map, word offsets.
    localparam logic [2:0]  SMR_A_CTRL       = 3'h0;
    localparam logic [2:0]  SMR_A_ONE        = 3'h1;
    localparam logic [2:0]  SMR_A_TWO        = 3'h2;
    localparam logic [2:0]  SMR_A_STAT       = 3'h3;
    localparam logic [2:0]  SMR_A_SHADOW1    = 3'h4;
    localparam logic [2:0]  SMR_A_SHADOW2    = 3'h5;
    localparam int          SMR_CTRL_GO1     = 0;
    localparam int          SMR_CTRL_GO2     = 1;
    localparam int          SMR_CTRL_X8      = 2;
    localparam int          SMR_ST_BUSY      = 0;
    localparam int          SMR_ST_REJ       = 1;
    localparam int          SMR_ST_DLLOFF    = 2;
    localparam int          SMR_ST_DONE      = 3;
    typedef enum logic [2:0] {
        SMR_IDLE   = 3'h0,
        SMR_ISSUE  = 3'h1,
        SMR_WAIT   = 3'h2,
        SMR_DLLRST = 3'h3,
        SMR_WAIT2  = 3'h4
    } smr_state_t;
endpackage

//--- hw/smr_wait_timer.sv
`timescale 1ns/1ps
module smr_wait_timer
    import smr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       start_in,
    output logic            busy_out
);
    typedef struct packed {
        logic [4:0] cnt;
        logic       busy;
    } smr_timer_t;
    smr_timer_t t_reg;
    smr_timer_t t_next;
    always_comb begin
        t_next = t_reg;
        if (start_in) begin
            t_next.cnt  = SMR_WAIT_CNT;
            t_next.busy = 1'b1;
        end else if (t_reg.cnt != 5'h00) begin
            t_next.cnt  = t_reg.cnt - 5'h01;
            t_next.busy = (t_reg.cnt != 5'h01);
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end
    assign busy_out = t_reg.busy;
endmodule

//--- verification/smr_ctrl_sva.sv
`timescale 1ns/1ps
module smr_ctrl_sva
    import smr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic        avs_waitrequest_out,
    input  wire logic        banks_idle_in,
    input  wire logic        mrs_cmd_out,
    input  wire logic [2:0]  mrs_bank_out,
    input  wire logic [18:0] mrs_addr_out,
    input  wire logic        odt_allow_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [4:0] gap_reg;
    logic       off_reg;
    logic       one;
    logic       two;
    assign one = mrs_cmd_out && mrs_bank_out == SMR_BANK_ONE;
    assign two = mrs_cmd_out && mrs_bank_out == SMR_BANK_TWO;
    // Gap starts saturated so the first command after reset is not judged.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gap_reg <= 5'h1F;
            off_reg <= 1'b0;
        end else begin
            gap_reg <= mrs_cmd_out ? 5'h00 : gap_reg + 5'(gap_reg != 5'h1F);
            if (one) begin
                off_reg <= mrs_addr_out[SMR_DLL_OFF_BIT];
            end
        end
    end
    sequence s_one_on;
        one && !mrs_addr_out[SMR_DLL_OFF_BIT];
    endsequence
    sequence s_dll_rst;
        mrs_cmd_out && mrs_bank_out == SMR_BANK_ZERO && mrs_addr_out[8];
    endsequence
    a_mrs_spacing: assert property (
        mrs_cmd_out |-> gap_reg >= 5'h0B)
        else $error("mode commands too close");
    a_mrs_idle: assert property (mrs_cmd_out |->
        $past(banks_idle_in) || $past(banks_idle_in, 2))
        else $error("mode command while banks busy");
    a_dll_reset_follows: assert property (
        s_one_on |-> ##[12:40] s_dll_rst)
        else $error("no loop reset after enable");
    a_one_rsvd_zero: assert property (
        one |-> !(|(mrs_addr_out & SMR_ONE_RSVD)))
        else $error("reserved bit set in register one");
    a_two_rsvd_zero: assert property (
        two |-> !(|(mrs_addr_out & SMR_TWO_RSVD)))
        else $error("reserved bit set in register two");
    a_refresh_excl: assert property (
        two |-> !(mrs_addr_out[6] && mrs_addr_out[7]))
        else $error("both refresh options set");
    a_off_cwl_six: assert property (
        two && off_reg |-> mrs_addr_out[5:3] == SMR_CWL6_CODE)
        else $error("write latency not six with loop off");
    a_off_no_term: assert property (one && mrs_addr_out[0] |->
        {mrs_addr_out[9], mrs_addr_out[6], mrs_addr_out[2]} == 3'h0
        ##1 !odt_allow_out[*3])
        else $error("termination kept with loop off");
    a_bus_answer: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle");
endmodule
bind smr_ctrl smr_ctrl_sva u_sva (.clk_in(clk_in), .rst_in(rst_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .banks_idle_in(banks_idle_in),
    .mrs_cmd_out(mrs_cmd_out), .mrs_bank_out(mrs_bank_out),
    .mrs_addr_out(mrs_addr_out), .odt_allow_out(odt_allow_out));

//--- verification/smr_ctrl_tb.sv
`timescale 1ns/1ps
module smr_ctrl_tb
    import smr_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [2:0]  adr = 3'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        busy = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rv;
    logic        wreq;
    logic        cmd;
    logic        odt;
    logic        idle;
    logic [2:0]  bank;
    logic [18:0] maddr;
    int          failures = 0;
    int          total_checks = 0;
    smr_ctrl u_dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .banks_idle_in(idle), .mrs_cmd_out(cmd), .mrs_bank_out(bank),
        .mrs_addr_out(maddr), .odt_allow_out(odt));
    smr_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_in), .mrs_cmd_in(cmd),
        .mrs_bank_in(bank), .mrs_addr_in(maddr), .busy_in(busy),
        .banks_idle_out(idle));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bus(bit w, logic [2:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50) begin
            failures++;
            tally_and_finish();
        end
    endtask
    // Waits for the command count as well as a clear busy bit, since busy reads low while a go is held pending.
    task automatic wait_done(int k);
        int n;
        n = 0;
        do begin
            bus(0, SMR_A_STAT, 0);
            n++;
        end while ((u_mem.n_cmd_reg != k || rv[SMR_ST_BUSY] !== 1'b0)
            && n < 60);
        if (n == 60) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic t_dll_on(bit x8);
        logic [18:0] e;
        int k;
        k = u_mem.n_cmd_reg;
        e = 19'h7FFFE & ~SMR_ONE_RSVD;
        e[SMR_TSTRB_BIT] = x8;
        bus(1, SMR_A_ONE, 32'h7FFFE);
        bus(1, SMR_A_CTRL, {29'h0, x8, 2'h1});
        wait_done(k + 2);
        chk("reg one", e, u_mem.mode_reg_one_reg);
        chk("last bank", SMR_BANK_ZERO, u_mem.last_bank_reg);
        chk("loop reset", 1, u_mem.last_addr_reg[8]);
        chk("odt allow", 1, odt);
        chk("mask on", !x8, u_mem.data_mask_on);
        chk("outputs off", 1, u_mem.outputs_off);
        chk("all term", 1, u_mem.all_term_ok);
        chk("dll on", 1, u_mem.dll_on);
        bus(0, SMR_A_SHADOW1, 0);
        chk("shadow one", e, rv);
        bus(0, SMR_A_ONE, 0);
        chk("value one", 32'h7FFFE, rv);
        $display("test dll on done");
    endtask
    task automatic t_dll_off();
        int k;
        k = u_mem.n_cmd_reg;
        bus(1, SMR_A_ONE, 32'h245);
        bus(1, SMR_A_TWO, 32'hFF);
        bus(1, SMR_A_CTRL, 32'h3);
        wait_done(k + 2);
        chk("reg one", 19'h00001, u_mem.mode_reg_one_reg);
        chk("reg two", 19'h00088, u_mem.mode_reg_two_reg);
        chk("last bank", SMR_BANK_TWO, u_mem.last_bank_reg);
        chk("odt allow", 0, odt);
        chk("dll off flag", 1, rv[SMR_ST_DLLOFF]);
        chk("dyn term", 0, u_mem.write_term_on);
        chk("dll off", 0, u_mem.dll_on);
        $display("test dll off done");
    endtask
    task automatic t_busy();
        int k;
        k = u_mem.n_cmd_reg;
        busy <= 1'b1;
        bus(1, SMR_A_CTRL, 32'h2);
        bus(0, SMR_A_STAT, 0);
        chk("rejected", 1, rv[SMR_ST_REJ]);
        repeat (20) @(posedge clk_in);
        chk("no command", k, u_mem.n_cmd_reg);
        busy <= 1'b0;
        wait_done(k + 1);
        chk("reg two", 19'h00088, u_mem.mode_reg_two_reg);
        bus(1, 3'h7, 32'hFFFF);
        bus(0, 3'h6, 0);
        chk("unmapped", 0, rv);
        bus(0, SMR_A_TWO, 0);
        chk("value two", 32'hFF, rv);
        $display("test busy done");
    endtask
    // The loop counts as off until a register one write says otherwise.
    task automatic t_status_reset();
        bus(0, SMR_A_STAT, 0);
        chk("status reset", 32'(1) << SMR_ST_DLLOFF, rv);
        chk("odt reset", 0, odt);
        $display("test reset state done");
    endtask
    task automatic t_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        t_status_reset();
        chk("reg one reset", 0, u_mem.mode_reg_one_reg);
        chk("reg two kept", 19'h00088, u_mem.mode_reg_two_reg);
        bus(0, SMR_A_SHADOW1, 0);
        chk("shadow reset", 0, rv);
        $display("test reset done");
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        t_status_reset();
        t_dll_on(1'b0);
        t_dll_on(1'b1);
        t_dll_off();
        t_busy();
        t_reset();
        tally_and_finish();
    end
endmodule

//--- verification/smr_mem_model.sv
`timescale 1ns/1ps
module smr_mem_model
    import smr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        mrs_cmd_in,
    input  wire logic [2:0]  mrs_bank_in,
    input  wire logic [18:0] mrs_addr_in,
    input  wire logic        busy_in,
    output logic             banks_idle_out
);
    logic [18:0] mode_reg_one_reg;
    logic [18:0] mode_reg_two_reg;
    logic [18:0] last_addr_reg;
    logic [2:0]  last_bank_reg;
    logic [7:0]  n_cmd_reg;
    logic        data_mask_on;
    logic        outputs_off;
    logic        all_term_ok;
    logic        write_term_on;
    logic        dll_on;
    assign banks_idle_out = !busy_in;
    assign data_mask_on  = !mode_reg_one_reg[SMR_TSTRB_BIT];
    assign outputs_off   = mode_reg_one_reg[SMR_QOFF_BIT];
    assign all_term_ok   = outputs_off
        && mode_reg_one_reg[SMR_WLVL_BIT];
    assign write_term_on =
        |mode_reg_two_reg[SMR_RTTWR_LO_BIT +: 2];
    // No self refresh here, so the loop state is what was last written.
    assign dll_on        = !mode_reg_one_reg[SMR_DLL_OFF_BIT];
    // The bench reset stands in for the device reset pin; register two
    // has no reset, so it stays unknown until first written.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_reg_one_reg <= 19'h00000;
            n_cmd_reg <= 8'h00;
            last_bank_reg <= 3'h7;
        end else if (mrs_cmd_in) begin
            n_cmd_reg <= n_cmd_reg + 8'h01;
            last_bank_reg <= mrs_bank_in;
            last_addr_reg <= mrs_addr_in;
            if (mrs_bank_in == SMR_BANK_ONE) begin
                mode_reg_one_reg <= mrs_addr_in;
            end
            if (mrs_bank_in == SMR_BANK_TWO) begin
                mode_reg_two_reg <= mrs_addr_in;
            end
        end
    end
endmodule
